// File: qsm_pkg.sv
package qsm_pkg;

   // ==========================================================
   // Function selection codes
   typedef enum logic [1:0] {
      QSM_FN_PRIMARY,
      QSM_FN_TIMER,
      QSM_FN_GPIO
   } qsm_func_t;

   // ==========================================================
   // Bit positions in the pull-up enable registers
   localparam int QSM_PC_INDEX_BIT = 6;
   localparam int QSM_PC_HOME_BIT  = 7;
   localparam int QSM_PE_CLK_BIT   = 4;
   localparam int QSM_PE_MO_BIT    = 5;
   localparam int QSM_PE_MI_BIT    = 6;
   localparam int QSM_PE_SEL_BIT   = 7;

   // ==========================================================
   // Values after reset
   localparam logic [7:0] QSM_PULLUP_RST = 8'hFF;
   localparam logic [1:0] QSM_SYNC_RST   = 2'h3;
   localparam logic       QSM_PIN_RST    = 1'h1;

endpackage : qsm_pkg

// File: qsm_sync.sv
module qsm_sync
   import qsm_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   // ==========================================================
   // Two-stage synchroniser; first stage read only by the second
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } qsm_sync_t;

   qsm_sync_t st_r;
   qsm_sync_t st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.meta = async_in;
      st_nxt.sync = st_r.meta;
   end

   // Pins idle high under their pull-ups, so reset to one
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= {(2 * WIDTH){QSM_PIN_RST}};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_out = st_r.sync;

endmodule : qsm_sync

// File: qsm_pad_cell.sv
module qsm_pad_cell (
   input  wire logic pullup_en,
   input  wire logic drive_en,
   input  wire logic drive_val,
   output logic      pad_out,
   output logic      pad_oe,
   output logic      pad_pu
);

   // ==========================================================
   // Pad control; the pull-up follows its register bit alone, so a
   // driven pin keeps it until software clears the bit
   always_comb begin
      pad_out = drive_val;
      pad_oe  = drive_en;
      pad_pu  = pullup_en;
   end

endmodule : qsm_pad_cell

// File: qsm_pin_mux.sv
// Behaviour
// - Index pin: index, timer ch2, port C6
// - Home pin: home, timer ch3, port C7
// - Index pull-up on at reset, off clearing C6
// - Home pull-up on at reset, off clearing C7
// - SPI pull-ups off clearing port E 4..7
// - SPI pins share port E, SPI default
// - SPI clock output as master, input slave
// - Master drives out-line half cycle early
// - Unselected slave releases master-in line
// - Slave drives in-line half cycle early
// - Select input marks slave transfer active
// - GPIO pins individually input or output
module qsm_pin_mux
   import qsm_pkg::*;
(
   input  wire logic      ref_clk,
   input  wire logic      rst_n,
   // Function selects from software
   input  qsm_func_t      index_func_sel,
   input  qsm_func_t      home_func_sel,
   input  wire logic      spi_clk_gpio_sel,
   input  wire logic      spi_mo_gpio_sel,
   input  wire logic      spi_mi_gpio_sel,
   input  wire logic      spi_sel_gpio_sel,
   // Pull-up enable registers (software written)
   input  wire logic [7:0] port_c_pullup_enable,
   input  wire logic [7:0] port_e_pullup_enable,
   // GPIO direction and output data
   input  wire logic [7:6] port_c_dir,
   input  wire logic [7:6] port_c_dout,
   input  wire logic [7:4] port_e_dir,
   input  wire logic [7:4] port_e_dout,
   output logic      [7:6] port_c_din,
   output logic      [7:4] port_e_din,
   // Timer channels 2 and 3
   input  wire logic      timer_a_ch2_oe,
   input  wire logic      timer_a_ch2_out,
   input  wire logic      timer_a_ch3_oe,
   input  wire logic      timer_a_ch3_out,
   output logic           timer_a_ch2_in,
   output logic           timer_a_ch3_in,
   // Quadrature decoder inputs
   output logic           quad0_index_in,
   output logic           quad0_home_in,
   // SPI core side
   input  wire logic      spi_master_mode,
   input  wire logic      spi_clk_out,
   input  wire logic      spi_mo_out,
   input  wire logic      spi_mi_out,
   output logic           spi_clk_in,
   output logic           spi_mo_in,
   output logic           spi_mi_in,
   output logic           spi_selected,
   // Pad: index and home
   input  wire logic      index_pad_i,
   output logic           index_pad_o,
   output logic           index_pad_oe,
   output logic           index_pad_pu,
   input  wire logic      home_pad_i,
   output logic           home_pad_o,
   output logic           home_pad_oe,
   output logic           home_pad_pu,
   // Pad: SPI pins
   input  wire logic      spi_unit0_clock_pin_i,
   output logic           spi_unit0_clock_pin_o,
   output logic           spi_unit0_clock_pin_oe,
   output logic           spi_unit0_clock_pin_pu,
   input  wire logic      spi_unit0_master_out_pin_i,
   output logic           spi_unit0_master_out_pin_o,
   output logic           spi_unit0_master_out_pin_oe,
   output logic           spi_unit0_master_out_pin_pu,
   input  wire logic      spi_unit0_master_in_pin_i,
   output logic           spi_unit0_master_in_pin_o,
   output logic           spi_unit0_master_in_pin_oe,
   output logic           spi_unit0_master_in_pin_pu,
   input  wire logic      spi_unit0_select_pin_i,
   output logic           spi_unit0_select_pin_o,
   output logic           spi_unit0_select_pin_oe,
   output logic           spi_unit0_select_pin_pu
);

   // ==========================================================
   // Registered state: selects, drive values, enables
   typedef struct packed {
      qsm_func_t  index_fn;
      qsm_func_t  home_fn;
      logic [3:0] spi_gpio;
      logic [5:0] oe;
      logic [5:0] dv;
      logic [5:0] pu;
   } qsm_state_t;

   qsm_state_t st_r;
   qsm_state_t st_nxt;
   logic [5:0] pin_sync;

   // Pin order in vectors: 0 index, 1 home, 2 clk, 3 mo, 4 mi, 5 sel
   // ==========================================================
   // Synchronise all pad inputs before use
   qsm_sync #(
      .WIDTH (6)
   ) u_qsm_sync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .async_in ({spi_unit0_select_pin_i, spi_unit0_master_in_pin_i,
                  spi_unit0_master_out_pin_i, spi_unit0_clock_pin_i,
                  home_pad_i, index_pad_i}),
      .sync_out (pin_sync)
   );

   function automatic logic slave_sel_active(input logic master, input logic gpio,
                                             input logic sel_pin);
      // Select pin is active low; a GPIO-owned select never selects
      slave_sel_active = ~master & ~gpio & ~sel_pin;
   endfunction : slave_sel_active

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic selected;
      selected            = 1'b0;
      st_nxt              = st_r;
      st_nxt.index_fn     = index_func_sel;
      st_nxt.home_fn      = home_func_sel;
      st_nxt.spi_gpio     = {spi_sel_gpio_sel, spi_mi_gpio_sel,
                             spi_mo_gpio_sel, spi_clk_gpio_sel};
      selected            = slave_sel_active(spi_master_mode, st_r.spi_gpio[3], pin_sync[5]);

      // Index pin
      case (st_r.index_fn)
         QSM_FN_PRIMARY: begin
            st_nxt.oe[0] = 1'b0;
            st_nxt.dv[0] = 1'b0;
         end
         QSM_FN_TIMER: begin
            st_nxt.oe[0] = timer_a_ch2_oe;
            st_nxt.dv[0] = timer_a_ch2_out;
         end
         QSM_FN_GPIO: begin
            st_nxt.oe[0] = port_c_dir[6];
            st_nxt.dv[0] = port_c_dout[6];
         end
         default: begin
            st_nxt.oe[0] = 1'b0;
            st_nxt.dv[0] = 1'b0;
         end
      endcase

      // Home pin
      case (st_r.home_fn)
         QSM_FN_PRIMARY: begin
            st_nxt.oe[1] = 1'b0;
            st_nxt.dv[1] = 1'b0;
         end
         QSM_FN_TIMER: begin
            st_nxt.oe[1] = timer_a_ch3_oe;
            st_nxt.dv[1] = timer_a_ch3_out;
         end
         QSM_FN_GPIO: begin
            st_nxt.oe[1] = port_c_dir[7];
            st_nxt.dv[1] = port_c_dout[7];
         end
         default: begin
            st_nxt.oe[1] = 1'b0;
            st_nxt.dv[1] = 1'b0;
         end
      endcase

      // SPI clock: out as master, in as slave
      if (st_r.spi_gpio[0]) begin
         st_nxt.oe[2] = port_e_dir[4];
         st_nxt.dv[2] = port_e_dout[4];
      end else begin
         st_nxt.oe[2] = spi_master_mode;
         st_nxt.dv[2] = spi_clk_out;
      end

      // Master-out: the SPI core sets data half a clock early
      if (st_r.spi_gpio[1]) begin
         st_nxt.oe[3] = port_e_dir[5];
         st_nxt.dv[3] = port_e_dout[5];
      end else begin
         st_nxt.oe[3] = spi_master_mode;
         st_nxt.dv[3] = spi_mo_out;
      end

      // Master-in: driven only by a selected slave, else released
      if (st_r.spi_gpio[2]) begin
         st_nxt.oe[4] = port_e_dir[6];
         st_nxt.dv[4] = port_e_dout[6];
      end else begin
         st_nxt.oe[4] = selected;
         st_nxt.dv[4] = spi_mi_out;
      end

      // Select pin is input-only in SPI mode
      if (st_r.spi_gpio[3]) begin
         st_nxt.oe[5] = port_e_dir[7];
         st_nxt.dv[5] = port_e_dout[7];
      end else begin
         st_nxt.oe[5] = 1'b0;
         st_nxt.dv[5] = 1'b0;
      end

      // Pull-ups follow register bits directly
      st_nxt.pu[0] = port_c_pullup_enable[QSM_PC_INDEX_BIT];
      st_nxt.pu[1] = port_c_pullup_enable[QSM_PC_HOME_BIT];
      st_nxt.pu[2] = port_e_pullup_enable[QSM_PE_CLK_BIT];
      st_nxt.pu[3] = port_e_pullup_enable[QSM_PE_MO_BIT];
      st_nxt.pu[4] = port_e_pullup_enable[QSM_PE_MI_BIT];
      st_nxt.pu[5] = port_e_pullup_enable[QSM_PE_SEL_BIT];
   end

   // ==========================================================
   // Reset: primary functions, nothing driven, pull-ups on
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r.index_fn <= QSM_FN_PRIMARY;
         st_r.home_fn  <= QSM_FN_PRIMARY;
         st_r.spi_gpio <= 4'h0;
         st_r.oe       <= 6'h00;
         st_r.dv       <= 6'h00;
         st_r.pu       <= QSM_PULLUP_RST[5:0];
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Pad cells, one per shared pin, fed straight from registers
   // Registered drive keeps glitches from the core off the pins
   qsm_pad_cell u_qsm_pad_cell_index (
      .pullup_en (st_r.pu[0]),
      .drive_en  (st_r.oe[0]),
      .drive_val (st_r.dv[0]),
      .pad_out   (index_pad_o),
      .pad_oe    (index_pad_oe),
      .pad_pu    (index_pad_pu)
   );

   qsm_pad_cell u_qsm_pad_cell_home (
      .pullup_en (st_r.pu[1]),
      .drive_en  (st_r.oe[1]),
      .drive_val (st_r.dv[1]),
      .pad_out   (home_pad_o),
      .pad_oe    (home_pad_oe),
      .pad_pu    (home_pad_pu)
   );

   qsm_pad_cell u_qsm_pad_cell_clock (
      .pullup_en (st_r.pu[2]),
      .drive_en  (st_r.oe[2]),
      .drive_val (st_r.dv[2]),
      .pad_out   (spi_unit0_clock_pin_o),
      .pad_oe    (spi_unit0_clock_pin_oe),
      .pad_pu    (spi_unit0_clock_pin_pu)
   );

   qsm_pad_cell u_qsm_pad_cell_mo (
      .pullup_en (st_r.pu[3]),
      .drive_en  (st_r.oe[3]),
      .drive_val (st_r.dv[3]),
      .pad_out   (spi_unit0_master_out_pin_o),
      .pad_oe    (spi_unit0_master_out_pin_oe),
      .pad_pu    (spi_unit0_master_out_pin_pu)
   );

   qsm_pad_cell u_qsm_pad_cell_mi (
      .pullup_en (st_r.pu[4]),
      .drive_en  (st_r.oe[4]),
      .drive_val (st_r.dv[4]),
      .pad_out   (spi_unit0_master_in_pin_o),
      .pad_oe    (spi_unit0_master_in_pin_oe),
      .pad_pu    (spi_unit0_master_in_pin_pu)
   );

   qsm_pad_cell u_qsm_pad_cell_select (
      .pullup_en (st_r.pu[5]),
      .drive_en  (st_r.oe[5]),
      .drive_val (st_r.dv[5]),
      .pad_out   (spi_unit0_select_pin_o),
      .pad_oe    (spi_unit0_select_pin_oe),
      .pad_pu    (spi_unit0_select_pin_pu)
   );

   // ==========================================================
   // Inputs to cores; unselected quadrature inputs read high, all other unselected inputs read zero
   always_comb begin
      quad0_index_in = (st_r.index_fn == QSM_FN_PRIMARY) ? pin_sync[0] : QSM_PIN_RST;
      quad0_home_in  = (st_r.home_fn == QSM_FN_PRIMARY) ? pin_sync[1] : QSM_PIN_RST;
      timer_a_ch2_in = (st_r.index_fn == QSM_FN_TIMER) ? pin_sync[0] : 1'b0;
      timer_a_ch3_in = (st_r.home_fn == QSM_FN_TIMER) ? pin_sync[1] : 1'b0;
      port_c_din     = pin_sync[1:0] & {st_r.home_fn == QSM_FN_GPIO,
                                        st_r.index_fn == QSM_FN_GPIO};
      port_e_din     = pin_sync[5:2] & st_r.spi_gpio;
      spi_clk_in     = st_r.spi_gpio[0] ? 1'b0 : pin_sync[2];
      spi_mo_in      = st_r.spi_gpio[1] ? 1'b0 : pin_sync[3];
      spi_mi_in      = st_r.spi_gpio[2] ? 1'b0 : pin_sync[4];
      spi_selected   = slave_sel_active(spi_master_mode, st_r.spi_gpio[3], pin_sync[5]);
   end

endmodule : qsm_pin_mux

// File: qsm_pin_mux_checker.sv
module qsm_pin_mux_checker
   import qsm_pkg::*;
(
   input logic       ref_clk,
   input logic       rst_n,
   input qsm_func_t  index_func_sel,
   input qsm_func_t  home_func_sel,
   input logic       spi_clk_gpio_sel,
   input logic       spi_mi_gpio_sel,
   input logic       spi_sel_gpio_sel,
   input logic [7:0] port_c_pullup_enable,
   input logic [7:6] port_c_dir,
   input logic [7:6] port_c_dout,
   input logic       spi_master_mode,
   input logic       index_pad_i,
   input logic       home_pad_i,
   input logic       quad0_index_in,
   input logic       timer_a_ch3_in,
   input logic       index_pad_pu,
   input logic       home_pad_o,
   input logic       home_pad_oe,
   input logic       spi_unit0_clock_pin_oe,
   input logic       spi_unit0_master_in_pin_oe,
   input logic       spi_unit0_select_pin_i,
   input logic       spi_selected
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // ==========================================================
   // Slave select, held four edges to cover synchroniser depth
   sequence s_sel_low;
      (!spi_master_mode && !spi_sel_gpio_sel && !spi_unit0_select_pin_i)[*4];
   endsequence
   sequence s_sel_high;
      (!spi_sel_gpio_sel && spi_unit0_select_pin_i)[*4];
   endsequence

   // ==========================================================
   // Properties
   property p_sel_on; s_sel_low |-> spi_selected; endproperty
   a_sel_on: assert property (p_sel_on) else $error("select low not taken");
   property p_sel_off; s_sel_high |-> !spi_selected; endproperty
   a_sel_off: assert property (p_sel_off) else $error("select high still taken");
   property p_mi_release; !$past(spi_mi_gpio_sel) && !$past(spi_mi_gpio_sel, 2)
      |-> spi_unit0_master_in_pin_oe == $past(spi_selected); endproperty
   a_mi_release: assert property (p_mi_release) else $error("master-in drive wrong");
   property p_clk_dir; !$past(spi_clk_gpio_sel) && !$past(spi_clk_gpio_sel, 2)
      |-> spi_unit0_clock_pin_oe == $past(spi_master_mode); endproperty
   a_clk_dir: assert property (p_clk_dir) else $error("clock pin direction wrong");
   property p_idx_pu; $past(rst_n) |-> index_pad_pu == $past(port_c_pullup_enable[6]); endproperty
   a_idx_pu: assert property (p_idx_pu) else $error("index pull-up wrong");
   property p_quad_idx; (index_func_sel == QSM_FN_PRIMARY)[*4]
      |-> quad0_index_in == $past(index_pad_i, 2); endproperty
   a_quad_idx: assert property (p_quad_idx) else $error("index input not routed");
   property p_tmr_home; (home_func_sel == QSM_FN_TIMER)[*4]
      |-> timer_a_ch3_in == $past(home_pad_i, 2); endproperty
   a_tmr_home: assert property (p_tmr_home) else $error("timer ch3 not routed");
   property p_gpio_home; (home_func_sel == QSM_FN_GPIO)[*4]
      |-> home_pad_oe == $past(port_c_dir[7]) && home_pad_o == $past(port_c_dout[7]); endproperty
   a_gpio_home: assert property (p_gpio_home) else $error("home gpio drive wrong");
endmodule : qsm_pin_mux_checker

bind qsm_pin_mux qsm_pin_mux_checker u_qsm_pin_mux_checker (.*);

// File: qsm_ext_model.sv
module qsm_ext_model (
   input  logic       ref_clk,
   input  logic [5:0] dut_o,
   input  logic [5:0] dut_oe,
   input  logic [5:0] dut_pu,
   input  logic [5:0] ext_en,
   input  logic [5:0] ext_val,
   output logic [5:0] pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] float_r = 6'h00;

   // ==========================================================
   // Wire resolution
   // A released line wanders, so a stale value cannot pass for a drive
   always @(negedge ref_clk) float_r <= ~float_r;
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (dut_oe[i]) pin[i] = dut_o[i];
         else if (ext_en[i]) pin[i] = ext_val[i];
         else if (dut_pu[i]) pin[i] = 1'b1;
         else pin[i] = float_r[i];
      end
   end
endmodule : qsm_ext_model

// File: qsm_pin_mux_tb.sv
module qsm_pin_mux_tb
   import qsm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   int err_count = 0;
   int tests_run = 0;
   qsm_func_t index_func_sel, home_func_sel;
   logic spi_clk_gpio_sel, spi_mo_gpio_sel, spi_mi_gpio_sel, spi_sel_gpio_sel;
   logic [7:0] port_c_pullup_enable, port_e_pullup_enable;
   logic [7:6] port_c_dir, port_c_dout, port_c_din;
   logic [7:4] port_e_dir, port_e_dout, port_e_din;
   logic timer_a_ch2_oe, timer_a_ch2_out, timer_a_ch3_oe, timer_a_ch3_out;
   logic timer_a_ch2_in, timer_a_ch3_in, quad0_index_in, quad0_home_in;
   logic spi_master_mode, spi_clk_out, spi_mo_out, spi_mi_out;
   logic spi_clk_in, spi_mo_in, spi_mi_in, spi_selected;
   logic index_pad_i, index_pad_o, index_pad_oe, index_pad_pu;
   logic home_pad_i, home_pad_o, home_pad_oe, home_pad_pu;
   logic spi_unit0_clock_pin_i, spi_unit0_clock_pin_o, spi_unit0_clock_pin_oe;
   logic spi_unit0_master_out_pin_i, spi_unit0_master_out_pin_o, spi_unit0_master_out_pin_oe;
   logic spi_unit0_master_in_pin_i, spi_unit0_master_in_pin_o, spi_unit0_master_in_pin_oe;
   logic spi_unit0_select_pin_i, spi_unit0_select_pin_o, spi_unit0_select_pin_oe;
   logic spi_unit0_clock_pin_pu, spi_unit0_master_out_pin_pu;
   logic spi_unit0_master_in_pin_pu, spi_unit0_select_pin_pu;
   logic [5:0] pin, dut_o, dut_oe, dut_pu, ext_en, ext_val, d;

   // ==========================================================
   // Pins packed select, master-in, master-out, clock, home, index
   assign {spi_unit0_select_pin_i, spi_unit0_master_in_pin_i, spi_unit0_master_out_pin_i,
           spi_unit0_clock_pin_i, home_pad_i, index_pad_i} = pin;
   assign dut_o = {spi_unit0_select_pin_o, spi_unit0_master_in_pin_o,
                   spi_unit0_master_out_pin_o, spi_unit0_clock_pin_o, home_pad_o, index_pad_o};
   assign dut_oe = {spi_unit0_select_pin_oe, spi_unit0_master_in_pin_oe,
                    spi_unit0_master_out_pin_oe, spi_unit0_clock_pin_oe, home_pad_oe, index_pad_oe};
   assign dut_pu = {spi_unit0_select_pin_pu, spi_unit0_master_in_pin_pu,
                    spi_unit0_master_out_pin_pu, spi_unit0_clock_pin_pu, home_pad_pu, index_pad_pu};

   qsm_pin_mux u_qsm_pin_mux (.*);
   qsm_ext_model u_qsm_ext_model (.*);

   always #5 ref_clk = ~ref_clk;

   function automatic logic [5:0] exp_pu(input logic [7:0] pc, input logic [7:0] pe);
      return {pe[7:4], pc[7:6]};
   endfunction : exp_pu

   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : step

   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      tests_run++;
      if (got !== want) begin
         err_count++;
         $display("ERROR %0t got %h want %h", $time, got, want);
      end
   endtask : chk

   task automatic final_report;
      if (err_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report

   initial begin
      #20us;
      err_count++;
      final_report();
   end

   initial begin
      void'($urandom(32'h8398FDA1));
      index_func_sel = QSM_FN_PRIMARY;
      home_func_sel = QSM_FN_PRIMARY;
      {spi_clk_gpio_sel, spi_mo_gpio_sel, spi_mi_gpio_sel, spi_sel_gpio_sel} = 4'h0;
      {port_c_pullup_enable, port_e_pullup_enable} = 16'hFFFF;
      {port_c_dir, port_c_dout, port_e_dir, port_e_dout} = 12'h000;
      {timer_a_ch2_oe, timer_a_ch2_out, timer_a_ch3_oe, timer_a_ch3_out} = 4'h0;
      {spi_master_mode, spi_clk_out, spi_mo_out, spi_mi_out} = 4'h0;
      ext_en = 6'h2F;
      ext_val = 6'h3F;
      step(4);
      chk(dut_pu, 6'h3F);
      chk(dut_oe, 6'h00);
      rst_n = 1'b1;
      for (int i = 0; i < 16; i++) begin
         port_c_pullup_enable = 8'($urandom);
         port_e_pullup_enable = 8'($urandom);
         step(2);
         chk(dut_pu, exp_pu(port_c_pullup_enable, port_e_pullup_enable));
      end
      for (int i = 0; i < 16; i++) begin
         ext_val = 6'($urandom);
         spi_mi_out = 1'($urandom);
         step(4);
         chk({spi_mo_in, spi_clk_in, quad0_home_in, quad0_index_in},
             ext_val[3:0]);
         chk({dut_oe[4:2], spi_selected}, {~ext_val[5], 2'h0, ~ext_val[5]});
         if (!ext_val[5]) chk(pin[4], spi_mi_out);
      end
      spi_master_mode = 1'b1;
      ext_en = 6'h33;
      for (int i = 0; i < 16; i++) begin
         {spi_clk_out, spi_mo_out} = 2'($urandom);
         ext_val = 6'($urandom);
         step(4);
         chk(dut_oe[4:2], 3'h3);
         chk({pin[3:2], spi_mi_in}, {spi_mo_out, spi_clk_out, ext_val[4]});
      end
      index_func_sel = QSM_FN_TIMER;
      home_func_sel = QSM_FN_TIMER;
      timer_a_ch2_oe = 1'b1;
      ext_en = 6'h32;
      for (int i = 0; i < 16; i++) begin
         timer_a_ch2_out = 1'($urandom);
         ext_val = 6'($urandom);
         step(4);
         chk({dut_oe[1:0], pin[0]}, {2'h1, timer_a_ch2_out});
         chk({timer_a_ch3_in, timer_a_ch2_in, quad0_index_in, quad0_home_in},
             {ext_val[1], timer_a_ch2_out, 2'h3});
      end
      index_func_sel = QSM_FN_GPIO;
      home_func_sel = QSM_FN_GPIO;
      {spi_clk_gpio_sel, spi_mo_gpio_sel, spi_mi_gpio_sel, spi_sel_gpio_sel} = 4'hF;
      for (int i = 0; i < 24; i++) begin
         {port_e_dir, port_c_dir, port_e_dout, port_c_dout} = 12'($urandom);
         d = {port_e_dir, port_c_dir};
         ext_en = ~d;
         ext_val = 6'($urandom);
         step(4);
         chk(dut_oe, d);
         chk({port_e_din, port_c_din},
             (d & {port_e_dout, port_c_dout}) | (~d & ext_val));
      end
      final_report();
   end
endmodule : qsm_pin_mux_tb
